//--- include/io_config_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the io configuration bank
// Assumes: included by its bare name from every design file that needs it
// Notes:   byte address of a register is four times its index
`ifndef IO_CONFIG_CFG_SVH
`define IO_CONFIG_CFG_SVH

// register indices
`define IO_CONFIG_ONE_IDX     8'h00
`define IO_CONFIG_TWO_IDX     8'h01
`define IO_STATUS_IDX         8'h10

// reset values, loaded by the power-up reset only
`define IO_CONFIG_ONE_RST     8'h08
`define IO_CONFIG_TWO_RST     8'h00
// writable bits of the second register, bits 5 and 1 are unused
`define IO_CONFIG_TWO_WMASK   8'hdd

// first register fields
`define SINGLE_DRIVE_BIT      7
`define SECOND_DRIVER_BIT     6
`define RX_LEVEL_BIT          5
`define TX_LEVEL_BIT          4
`define CRYSTAL_FREQ_BIT      3
`define HOST_CLK_HI_BIT       2
`define HOST_CLK_LO_BIT       1
`define LOW_FREQ_CLOCK_DISABLE_BIT        0

// second register fields
`define LOW_SUPPLY_BIT        7
`define DIG_REG_OFF_BIT       6
`define PD_SELECTED_BIT       4
`define PD_IDLE_BIT           3
`define STRONG_DRIVE_BIT      2
`define SLOW_RAMP_BIT         0

// fifo water levels in bytes
`define RX_WATER_LOW          7'h40
`define RX_WATER_HIGH         7'h50
`define TX_WATER_LOW          6'h20
`define TX_WATER_HIGH         6'h10

// host clock select codes
`define HOST_CLK_DIV4         2'h0
`define HOST_CLK_DIV2         2'h1
`define HOST_CLK_DIV1         2'h2
`define HOST_CLK_OFF          2'h3

// timing
`define CLK_PERIOD_NS         25
`define TX_RAMP_TIME_NS       10000
`define TX_RAMP_CYCLES        ((`TX_RAMP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- include/io_config_pkg.sv
// Purpose: shared types of the io configuration bank
// Assumes: nothing beyond the cfg header
// Notes:   states carry no explicit codes
package io_config_pkg;

  // bus handshake states
  typedef enum logic [0:0] {bus_idle_s, bus_ack_s} bus_state_t;

  // transmitter ramp states
  typedef enum logic [1:0] {ramp_off_s, ramp_up_s, ramp_full_s} ramp_state_t;

endpackage : io_config_pkg

//--- hw/host_clk_gen.sv
// Purpose: host clock pin source, derived from the crystal or the low-frequency clock
// Assumes: xtal_clk_i and lf_clk_i are slow against ref_clk_i and taken as synchronous
// Notes:   a 27.12 MHz crystal is only resolved approximately at a 40 MHz sampling rate
`timescale 1ns/10ps
`include "io_config_cfg.svh"
module host_clk_gen
  import io_config_pkg::*;
(
  input  wire logic       ref_clk_i,      // system clock
  input  wire logic       rst_i,          // power-up reset
  input  wire logic       xtal_clk_i,     // crystal oscillator clock level
  input  wire logic       xtal_running_i, // crystal oscillator is running
  input  wire logic       crystal_27_i,   // crystal is 27.12 MHz
  input  wire logic [1:0] host_clk_sel_i, // output frequency code
  input  wire logic       lf_clk_i,       // 32 kHz clock level
  input  wire logic       lf_disable_i,   // suppress the 32 kHz clock
  output logic            host_clk_o      // host clock pin
);

  logic       xtal_prev;
  logic [2:0] edge_cnt;
  logic       next_host_clk;

  // rising crystal edges feed a ripple-free divider
  wire        xtal_rise = xtal_clk_i & ~xtal_prev;
  // with a 27.12 MHz crystal every tap moves down one divider stage
  wire        tap_div1  = crystal_27_i ? edge_cnt[0] : xtal_clk_i;
  wire        tap_div2  = crystal_27_i ? edge_cnt[1] : edge_cnt[0];
  wire        tap_div4  = crystal_27_i ? edge_cnt[2] : edge_cnt[1];
  wire        xtal_tap  = (host_clk_sel_i == `HOST_CLK_DIV1) ? tap_div1 :
                          (host_clk_sel_i == `HOST_CLK_DIV2) ? tap_div2 : tap_div4;

  // code 11 wins over every source, the pin then stays low
  assign next_host_clk = (host_clk_sel_i == `HOST_CLK_OFF) ? 1'b0 :
                         xtal_running_i ? xtal_tap :
                         (lf_clk_i & ~lf_disable_i);

  // divider and registered pin
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      xtal_prev  <= 1'b0;
      edge_cnt   <= 3'h0;
      host_clk_o <= 1'b0;
    end
    else
    begin
      xtal_prev  <= xtal_clk_i;
      edge_cnt   <= xtal_rise ? edge_cnt + 3'h1 : edge_cnt;
      host_clk_o <= next_host_clk;
    end
  end

endmodule : host_clk_gen

//--- hw/dout_pad_ctrl.sv
// Purpose: pull-down and drive strength control of the serial data-out pad
// Assumes: cs_n_i and dout_oe_i are synchronous to ref_clk_i
// Notes:   outputs lag their causes by one clock
`timescale 1ns/10ps
`include "io_config_cfg.svh"
module dout_pad_ctrl
  import io_config_pkg::*;
(
  input  wire logic ref_clk_i,         // system clock
  input  wire logic rst_i,             // power-up reset
  input  wire logic cs_n_i,            // serial chip select, active low
  input  wire logic dout_oe_i,         // serial core drives data-out
  input  wire logic pd_selected_i,     // pull-down while selected and undriven
  input  wire logic pd_idle_i,         // pull-down while deselected
  input  wire logic strong_drive_i,    // raise data-out drive strength
  output logic      dout_pulldown_o,   // pull-down enable of data-out
  output logic      dout_strong_o      // high drive strength of data-out
);

  // never pull down against our own driver while selected; the idle pull-down ignores dout_oe_i
  wire pull_sel  = pd_selected_i & ~cs_n_i & ~dout_oe_i;
  wire pull_idle = pd_idle_i & cs_n_i;

  // registered pad controls
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_pulldown_o <= 1'b0;
      dout_strong_o   <= 1'b0;
    end
    else
    begin
      dout_pulldown_o <= pull_sel | pull_idle;
      dout_strong_o   <= strong_drive_i;
    end
  end

endmodule : dout_pad_ctrl

//--- hw/io_config_regs.sv
// Purpose: io configuration register bank of the reader front end, reached over avalon-mm
// Assumes: rst_i is the power-up reset; all pins are synchronous to ref_clk_i
// Notes:   each access takes one wait cycle; unmapped reads return zero
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "io_config_cfg.svh"
module io_config_regs
  import io_config_pkg::*;
(
  input  wire logic        ref_clk_i,               // 40 MHz system clock
  input  wire logic        rst_i,                   // power-up reset, active high
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,           // byte address
  input  wire logic        avs_read_i,              // read request
  input  wire logic        avs_write_i,             // write request
  input  wire logic [31:0] avs_writedata_i,         // write data
  input  wire logic [3:0]  avs_byteenable_i,        // byte lanes
  output logic [31:0]      avs_readdata_o,          // read data
  output logic             avs_waitrequest_o,       // stall request
  // antenna drivers
  output logic             differential_drive_o,    // both drivers in antiphase
  output logic             antenna_driver_a_en_o,   // driver a in use
  output logic             antenna_driver_b_en_o,   // driver b in use
  output logic             rx_input_b_sel_o,        // receive pair b in use
  // fifo thresholds
  output logic [6:0]       rx_water_level_o,        // receive threshold in bytes
  output logic [5:0]       tx_water_level_o,        // transmit threshold in bytes
  // oscillator and host clock
  output logic             crystal_freq_sel_o,      // 27.12 MHz crystal
  input  wire logic        xtal_clk_i,              // crystal clock level
  input  wire logic        xtal_running_i,          // crystal oscillator running
  input  wire logic        lf_clk_i,                // 32 kHz clock level
  output logic             host_clk_o,              // host clock pin
  // supply
  output logic             low_supply_range_sel_o,  // 3.3 V supply range
  output logic             digital_reg_off_o,       // digital regulator off
  // serial data-out pad
  input  wire logic        cs_n_i,                  // serial chip select, active low
  input  wire logic        dout_oe_i,               // serial core drives data-out
  output logic             dout_pulldown_o,         // data-out pull-down enable
  output logic             dout_strong_o,           // data-out high drive
  // transmitter
  input  wire logic        tx_on_i,                 // transmitter switched on
  output logic             tx_ramp_busy_o,          // slow ramp in progress
  output logic             tx_full_power_o          // transmitter at full level
);

  // printed offsets are indices, the bus sees four bytes per register
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'h0};
  endfunction : byte_addr

  // ramp length as a counter value
  localparam logic [8:0] RAMP_LAST = 9'(`TX_RAMP_CYCLES - 1);

  logic [7:0]  io_config_one;
  logic [7:0]  io_config_two;
  bus_state_t  bus_state;
  bus_state_t  next_bus_state;
  ramp_state_t ramp_state;
  ramp_state_t next_ramp_state;
  logic [8:0]  ramp_cnt;
  logic [8:0]  next_ramp_cnt;
  logic [31:0] next_readdata;

  // field views of the first register
  wire       single_drive     = io_config_one[`SINGLE_DRIVE_BIT];
  wire       second_driver_select = io_config_one[`SECOND_DRIVER_BIT];
  wire       rx_water_level_sel   = io_config_one[`RX_LEVEL_BIT];
  wire       tx_water_level_sel   = io_config_one[`TX_LEVEL_BIT];
  wire       host_clk_sel_hi  = io_config_one[`HOST_CLK_HI_BIT];
  wire       host_clk_sel_lo  = io_config_one[`HOST_CLK_LO_BIT];
  wire       low_freq_clock_disable = io_config_one[`LOW_FREQ_CLOCK_DISABLE_BIT];
  wire [1:0] host_clk_sel     = {host_clk_sel_hi, host_clk_sel_lo};

  // field views of the second register
  wire       dout_pulldown_selected = io_config_two[`PD_SELECTED_BIT];
  wire       dout_pulldown_idle     = io_config_two[`PD_IDLE_BIT];
  wire       strong_drive     = io_config_two[`STRONG_DRIVE_BIT];
  wire       slow_ramp        = io_config_two[`SLOW_RAMP_BIT];

  // address decode
  wire       bus_req  = avs_read_i | avs_write_i;
  wire       hit_one  = (avs_address_i == byte_addr(`IO_CONFIG_ONE_IDX));
  wire       hit_two  = (avs_address_i == byte_addr(`IO_CONFIG_TWO_IDX));
  wire       hit_stat = (avs_address_i == byte_addr(`IO_STATUS_IDX));

  // a write lands only at the edge where waitrequest is low
  wire       commit   = avs_write_i & (bus_state == bus_ack_s) & avs_byteenable_i[0];
  wire       wr_one   = commit & hit_one;
  wire       wr_two   = commit & hit_two;

  // status word shows live block state, read-only
  wire [7:0] status_byte = {3'h0, tx_full_power_o, tx_ramp_busy_o,
                            dout_pulldown_o, host_clk_o, xtal_running_i};

  // read mux, unused bits of the second register come back as zero
  wire [7:0] read_byte = hit_one  ? io_config_one :
                         hit_two  ? (io_config_two & `IO_CONFIG_TWO_WMASK) :
                         hit_stat ? status_byte : 8'h00;

  // one wait cycle per access; readdata is loaded in the first cycle and stands in the second
  assign next_bus_state = (bus_state == bus_idle_s && bus_req) ? bus_ack_s : bus_idle_s;
  assign next_readdata  = (bus_state == bus_idle_s && avs_read_i) ? {24'h0, read_byte} :
                          avs_readdata_o;
  assign avs_waitrequest_o = bus_req & (bus_state == bus_idle_s);

  // bus handshake
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_state      <= bus_idle_s;
      avs_readdata_o <= 32'h0;
    end
    else
    begin
      bus_state      <= next_bus_state;
      avs_readdata_o <= next_readdata;
    end
  end

  // configuration storage; only the power-up reset loads defaults, no command reaches here
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      io_config_one <= `IO_CONFIG_ONE_RST;
      io_config_two <= `IO_CONFIG_TWO_RST;
    end
    else
    begin
      if (wr_one)
        io_config_one <= avs_writedata_i[7:0];
      if (wr_two)
        io_config_two <= avs_writedata_i[7:0] & `IO_CONFIG_TWO_WMASK;
    end
  end

  // antenna driver routing; the pair select matters only in single drive
  assign differential_drive_o  = ~single_drive;
  assign antenna_driver_a_en_o = ~single_drive | ~second_driver_select;
  assign antenna_driver_b_en_o = ~single_drive | second_driver_select;
  assign rx_input_b_sel_o      = single_drive & second_driver_select;

  // fifo thresholds in bytes
  assign rx_water_level_o = rx_water_level_sel ? `RX_WATER_HIGH : `RX_WATER_LOW;
  assign tx_water_level_o = tx_water_level_sel ? `TX_WATER_HIGH : `TX_WATER_LOW;

  // crystal and supply selections go straight to the analog side
  assign crystal_freq_sel_o     = io_config_one[`CRYSTAL_FREQ_BIT];
  assign low_supply_range_sel_o = io_config_two[`LOW_SUPPLY_BIT];
  assign digital_reg_off_o      = io_config_two[`DIG_REG_OFF_BIT];

  // host clock pin source
  host_clk_gen u_host_clk
  (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .xtal_clk_i     (xtal_clk_i),
    .xtal_running_i (xtal_running_i),
    .crystal_27_i   (crystal_freq_sel_o),
    .host_clk_sel_i (host_clk_sel),
    .lf_clk_i       (lf_clk_i),
    .lf_disable_i   (low_freq_clock_disable),
    .host_clk_o     (host_clk_o)
  );

  // data-out pad control
  dout_pad_ctrl u_dout_pad
  (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .cs_n_i         (cs_n_i),
    .dout_oe_i      (dout_oe_i),
    .pd_selected_i  (dout_pulldown_selected),
    .pd_idle_i      (dout_pulldown_idle),
    .strong_drive_i (strong_drive),
    .dout_pulldown_o(dout_pulldown_o),
    .dout_strong_o  (dout_strong_o)
  );

  // transmitter ramp; a drop of tx_on aborts the ramp at once, so with slow_ramp set a short pulse never reaches full power
  always_comb
  begin
    next_ramp_state = ramp_state;
    next_ramp_cnt   = ramp_cnt;
    case (ramp_state)
      ramp_off_s:
      begin
        next_ramp_cnt = 9'h0;
        if (tx_on_i)
          next_ramp_state = slow_ramp ? ramp_up_s : ramp_full_s;
      end
      ramp_up_s:
      begin
        if (!tx_on_i)
          next_ramp_state = ramp_off_s;
        else if (ramp_cnt == RAMP_LAST)
          next_ramp_state = ramp_full_s;
        else
          next_ramp_cnt = ramp_cnt + 9'h1;
      end
      ramp_full_s:
      begin
        if (!tx_on_i)
          next_ramp_state = ramp_off_s;
      end
      default:
      begin
        next_ramp_state = ramp_off_s;
        next_ramp_cnt   = 9'h0;
      end
    endcase
  end

  // ramp state register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ramp_state <= ramp_off_s;
      ramp_cnt   <= 9'h0;
    end
    else
    begin
      ramp_state <= next_ramp_state;
      ramp_cnt   <= next_ramp_cnt;
    end
  end

  // ramp status is a decode of the state flop
  assign tx_ramp_busy_o  = (ramp_state == ramp_up_s);
  assign tx_full_power_o = (ramp_state == ramp_full_s);

endmodule : io_config_regs

//--- verification/io_config_regs_sva.sv
// Purpose: port-level checks of the io configuration bank
// Assumes: shadows follow every accepted low-lane write
// Notes:   pad and host clock outputs lag their causes by one clock
`timescale 1ns/10ps
module io_config_regs_sva
  import io_config_pkg::*;
(
  input wire logic        ref_clk_i,             // clock
  input wire logic        rst_i,                 // reset
  input wire logic [7:0]  avs_address_i,         // address
  input wire logic        avs_read_i,            // read
  input wire logic        avs_write_i,           // write
  input wire logic [31:0] avs_writedata_i,       // data in
  input wire logic [3:0]  avs_byteenable_i,      // lanes
  input wire logic [31:0] avs_readdata_o,        // data out
  input wire logic        avs_waitrequest_o,     // stall
  input wire logic        differential_drive_o,  // differential
  input wire logic        antenna_driver_a_en_o, // driver a
  input wire logic        antenna_driver_b_en_o, // driver b
  input wire logic        rx_input_b_sel_o,      // pair b
  input wire logic        xtal_running_i,        // crystal on
  input wire logic        lf_clk_i,              // slow clock
  input wire logic        host_clk_o,            // host clock
  input wire logic        cs_n_i,                // select
  input wire logic        dout_oe_i,             // data-out driven
  input wire logic        dout_pulldown_o,       // pull-down
  input wire logic        dout_strong_o,         // strong drive
  input wire logic        tx_on_i,               // tx on
  input wire logic        tx_ramp_busy_o,        // ramping
  input wire logic        tx_full_power_o        // full level
);
  logic [7:0] one;      // shadow of the first register
  logic [7:0] two;      // shadow of the second register
  logic [9:0] busy_run; // consecutive ramp cycles
  wire        acc     = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire        pd_want = (two[4] && !cs_n_i && !dout_oe_i) || (two[3] && cs_n_i);

  // shadows only move on accepted writes, so refused ones show as mismatches
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      one      <= 8'h08;
      two      <= 8'h00;
      busy_run <= 10'h000;
    end
    else
    begin
      if (acc && avs_address_i == 8'h00)
        one <= avs_writedata_i[7:0];
      if (acc && avs_address_i == 8'h04)
        two <= avs_writedata_i[7:0] & 8'hdd;
      busy_run <= tx_ramp_busy_o ? busy_run + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req; avs_read_i || avs_write_i; endsequence
  sequence s_done; s_req ##0 !avs_waitrequest_o; endsequence
  sequence s_off_on; !rst_i && tx_on_i && !tx_ramp_busy_o && !tx_full_power_o; endsequence

  property p_one_wait; s_req ##0 avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest held past one cycle");
  property p_rearm; s_done |=> !(avs_read_i || avs_write_i) || avs_waitrequest_o; endproperty
  a_rearm: assert property (p_rearm) else $error("new request answered without a wait");
  property p_diff; differential_drive_o == !one[7]; endproperty
  a_diff: assert property (p_diff) else $error("drive mode wrong");
  property p_pick; one[7] |-> {antenna_driver_a_en_o, antenna_driver_b_en_o, rx_input_b_sel_o} ==
    {!one[6], one[6], one[6]};
  endproperty
  a_pick: assert property (p_pick) else $error("single driver choice wrong");
  property p_code_off; one[2:1] == 2'h3 |=> !host_clk_o; endproperty
  a_code_off: assert property (p_code_off) else $error("host clock not held low");
  // the release edge still resets the pin register, so it must not start an attempt
  property p_lf; !rst_i && !xtal_running_i && one[2:1] != 2'h3 |=>
    host_clk_o == ($past(lf_clk_i) && !$past(one[0])); endproperty
  a_lf: assert property (p_lf) else $error("slow clock path wrong");
  property p_pd; 1'b1 |=> dout_pulldown_o == $past(pd_want); endproperty
  a_pd: assert property (p_pd) else $error("pull-down wrong");
  property p_strong; 1'b1 |=> dout_strong_o == $past(two[2]); endproperty
  a_strong: assert property (p_strong) else $error("drive strength wrong");
  property p_slow_start; s_off_on ##0 two[0] |=> tx_ramp_busy_o && !tx_full_power_o; endproperty
  a_slow_start: assert property (p_slow_start) else $error("slow ramp did not start");
  property p_slow_len; $fell(tx_ramp_busy_o) && tx_full_power_o |-> busy_run == 10'h190; endproperty
  a_slow_len: assert property (p_slow_len) else $error("slow ramp length wrong");
  property p_fast; s_off_on ##0 !two[0] |=> tx_full_power_o && !tx_ramp_busy_o; endproperty
  a_fast: assert property (p_fast) else $error("fast ramp wrong");
  property p_gaps; s_done ##0 (avs_read_i && avs_address_i == 8'h04) |->
    (avs_readdata_o & 32'h22) == 32'h0; endproperty
  a_gaps: assert property (p_gaps) else $error("unused bits read nonzero");
endmodule : io_config_regs_sva

bind io_config_regs io_config_regs_sva u_sva (
  .ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .differential_drive_o, .antenna_driver_a_en_o, .antenna_driver_b_en_o,
  .rx_input_b_sel_o, .xtal_running_i, .lf_clk_i, .host_clk_o, .cs_n_i, .dout_oe_i, .dout_pulldown_o,
  .dout_strong_o, .tx_on_i, .tx_ramp_busy_o, .tx_full_power_o
);

//--- verification/host_master_model.sv
// Purpose: host side master issuing avalon-mm register accesses
// Assumes: access is entered just after a rising clock edge
// Notes:   released write data shows the inverse of the last value
`timescale 1ns/10ps
module host_master_model
  import io_config_pkg::*;
(
  input  wire logic        ref_clk_i,         // clock
  input  wire logic        avs_waitrequest_i, // stall
  output logic [7:0]       avs_address_o,     // address
  output logic             avs_read_o,        // read
  output logic             avs_write_o,       // write
  output logic [31:0]      avs_writedata_o,   // data
  output logic [3:0]       avs_byteenable_o   // lanes
);
  // idle bus from time zero
  initial
  begin
    avs_address_o    = 8'h00;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = 32'h0;
    avs_byteenable_o = 4'h0;
  end

  // gap lets the host be prompt or slow; request stands until waitrequest is low
  task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                        input int gap);
    repeat (gap) @(posedge ref_clk_i);
    avs_address_o    <= a;
    avs_writedata_o  <= d;
    avs_byteenable_o <= be;
    avs_read_o       <= rd;
    avs_write_o      <= !rd;
    @(posedge ref_clk_i);
    while (avs_waitrequest_i)
      @(posedge ref_clk_i);
    avs_read_o      <= 1'b0;
    avs_write_o     <= 1'b0;
    avs_writedata_o <= ~d;
    @(posedge ref_clk_i);
  endtask : access
endmodule : host_master_model

//--- verification/io_config_regs_bench.sv
// Purpose: self-checking bench of the io configuration bank
// Assumes: reads are scored by a monitor against queued expectations
// Notes:   crystal toggles every two clocks, slow clock is random
`timescale 1ns/10ps
module io_config_regs_bench
  import io_config_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        rst_i, xtal_clk_i, xtal_running_i, lf_clk_i, cs_n_i, dout_oe_i, tx_on_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic        differential_drive_o, antenna_driver_a_en_o, antenna_driver_b_en_o, rx_input_b_sel_o;
  logic [6:0]  rx_water_level_o;
  logic [5:0]  tx_water_level_o;
  logic        crystal_freq_sel_o, host_clk_o, low_supply_range_sel_o, digital_reg_off_o;
  logic        dout_pulldown_o, dout_strong_o, tx_ramp_busy_o, tx_full_power_o;
  logic [31:0] rd_q[$];
  logic [7:0]  one, two;
  int          failures, compares, cycles, h, l, n;
  wire  [2:0]  drv = {antenna_driver_a_en_o, antenna_driver_b_en_o, rx_input_b_sel_o};
  wire  [2:0]  sup = {crystal_freq_sel_o, low_supply_range_sel_o, digital_reg_off_o};
  wire  [12:0] lvl = {rx_water_level_o, tx_water_level_o};

  io_config_regs u_io_config_regs (.*);
  host_master_model u_host_master_model (.ref_clk_i, .avs_waitrequest_i(avs_waitrequest_o),
    .avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
    .avs_writedata_o(avs_writedata_i), .avs_byteenable_o(avs_byteenable_i));

  always #12.5 ref_clk_i = ~ref_clk_i;

  // crystal and slow clock stimuli, plus the hang guard
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles[0])
      xtal_clk_i <= ~xtal_clk_i;
    lf_clk_i <= 1'($urandom);
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  // read monitor: oldest expectation against each completed read
  always @(posedge ref_clk_i)
    if (!rst_i && avs_read_i && !avs_waitrequest_o)
      check("readdata", rd_q.pop_front(), avs_readdata_o);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic check_near(input string what, input int exp, input int got);
    compares++;
    if (got > exp + 1 || got + 1 < exp)
    begin
      failures++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_near

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    if (be[0] && a == 8'h00)
      one = d[7:0];
    if (be[0] && a == 8'h04)
      two = d[7:0] & 8'hdd;
    u_host_master_model.access(1'b0, a, d, be, $urandom_range(0, 2));
  endtask : wr

  task automatic rd(input logic [7:0] a);
    // status is read only with the transmitter at full power and all else quiet
    rd_q.push_back(a == 8'h00 ? {24'h0, one} : a == 8'h04 ? {24'h0, two} : a == 8'h40 ? 32'h10 : 32'h0);
    u_host_master_model.access(1'b1, a, $urandom, 4'hf, $urandom_range(0, 2));
  endtask : rd

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    one = 8'h08;
    two = 8'h00;
  endtask : do_reset

  task automatic outs();
    check("differential", {31'h0, !one[7]}, {31'h0, differential_drive_o});
    check("drivers", {29'h0, !one[7] || !one[6], !one[7] || one[6], one[7] && one[6]}, {29'h0, drv});
    check("levels", {19'h0, (one[5] ? 7'h50 : 7'h40), (one[4] ? 6'h10 : 6'h20)}, {19'h0, lvl});
    check("supply", {29'h0, one[3], two[7], two[6]}, {29'h0, sup});
  endtask : outs

  task automatic count(output int hr, output int lr);
    logic ph, pl;
    hr = 0;
    lr = 0;
    repeat (256)
    begin
      ph = host_clk_o;
      pl = lf_clk_i;
      @(posedge ref_clk_i);
      hr += int'(host_clk_o !== 1'b0 && ph !== 1'b1); // an unknown pin counts as a rise
      lr += int'(lf_clk_i && !pl);
    end
  endtask : count

  task automatic tally_and_finish();
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    void'($urandom(63));
    {rst_i, xtal_clk_i, xtal_running_i, lf_clk_i, dout_oe_i, tx_on_i, cs_n_i} = 7'h41;
    {failures, compares, cycles} = '0;
    do_reset();
    rd(8'h00);
    rd(8'h04);
    outs();
    repeat (12)
    begin
      wr(8'h00, $urandom, 4'hf);
      wr(8'h04, $urandom, 4'hf);
      rd(8'h00);
      rd(8'h04);
      outs();
    end
    wr(8'h00, 32'h77, 4'he);
    wr(8'h08, 32'hff, 4'hf);
    rd(8'h08);
    rd(8'h00);
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h04, {27'h0, i[0], i[1], i[3], 2'h0}, 4'hf);
      cs_n_i <= i[2];
      dout_oe_i <= i[3];
      repeat (2) @(posedge ref_clk_i);
      check("pulldown", {31'h0, i[0] && !i[2] && !i[3] || i[1] && i[2]}, {31'h0, dout_pulldown_o});
      check("strong", {31'h0, i[3]}, {31'h0, dout_strong_o});
    end
    xtal_running_i <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h00, {28'h0, k[2], k[1:0], 1'b0}, 4'hf);
      repeat (8) @(posedge ref_clk_i);
      count(h, l);
      check_near("host rises", (k[1:0] == 2'h3) ? 0 : 64 >> (2 - k[1:0] + k[2]), h);
    end
    xtal_running_i <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h00, (k == 2) ? 32'h6 : {30'h0, k[1:0]}, 4'hf);
      repeat (8) @(posedge ref_clk_i);
      count(h, l);
      check_near("slow rises", (k == 0) ? l : 0, h);
    end
    wr(8'h04, 32'h01, 4'hf);
    tx_on_i <= 1'b1;
    n = 0;
    repeat (1000)
    begin
      @(posedge ref_clk_i);
      n += int'(tx_ramp_busy_o);
      if (tx_full_power_o)
        break;
    end
    check("ramp cycles", 32'h190, n);
    tx_on_i <= 1'b0;
    wr(8'h04, 32'h00, 4'hf);
    tx_on_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check("fast ramp", 32'h2, {30'h0, tx_full_power_o, tx_ramp_busy_o});
    wr(8'h00, 32'hf7, 4'hf);
    wr(8'h04, 32'hdd, 4'hf);
    do_reset();
    rd(8'h00);
    rd(8'h04);
    wr(8'h00, 32'h09, 4'hf);
    rd(8'h40);
    repeat (4) @(posedge ref_clk_i);
    tally_and_finish();
  end
endmodule : io_config_regs_bench
